// ==== design/annp_regs.sv ====
// Next page transmit and partner page registers on Wishbone
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/100ps
module annp_regs
   import annp_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   // Clock and reset
   input  wire logic                ref_clk,
   input  wire logic                reset_n,
   // Wishbone classic slave
   input  wire logic                wb_cyc,
   input  wire logic                wb_stb,
   input  wire logic                wb_we,
   input  wire logic [ADDR_W-1:0]   wb_adr,
   input  wire logic [3:0]          wb_sel,
   input  wire logic [31:0]         wb_dat_wr,
   output logic      [31:0]         wb_dat_rd,
   output logic                     wb_ack,
   // Arbitration side
   input  wire logic                an_restart,
   input  wire logic                page_load,
   input  wire logic                rx_page_valid,
   input  wire logic [15:0]         rx_page,
   output logic      [15:0]         tx_page
);
   import annp_pkg::*;

   // Refused at elaboration: index 8 needs four word-index bits
   if (ADDR_W < 6)
   begin : g_adr_check
      $error("ADDR_W too small to reach register index 8");
   end

   // Word index decode, shared by read and write paths
   function automatic logic reg_hit(input logic [ADDR_W-1:0] adr,
                                    input logic [3:0]        idx);
      reg_hit = (adr[ADDR_W-1:2] == {{(ADDR_W-6){1'b0}}, idx});
   endfunction

   logic        ack_ff;
   logic        nxt_ack;
   logic [31:0] rd_ff;
   logic [31:0] nxt_rd;
   logic [15:0] npt_ff;
   logic [15:0] nxt_npt;
   logic [15:0] rx_ff;
   logic [15:0] nxt_rx;
   logic [15:0] tx_ff;
   logic [15:0] nxt_tx;
   logic        tog;
   logic        req;
   logic        hit_npt;
   logic        hit_rx;
   logic [15:0] npt_view;
   logic [15:0] lane_mask;

   annp_toggle u_toggle
   (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .restart (an_restart),
      .sent    (page_load),
      .tog     (tog)
   );

   // New request only when no ack is out, so each access acts once
   assign req       = wb_cyc && wb_stb && !ack_ff;
   assign hit_npt   = reg_hit(wb_adr, NPT_IDX);
   assign hit_rx    = reg_hit(wb_adr, RX_IDX);
   assign lane_mask = {{8{wb_sel[1]}}, {8{wb_sel[0]}}} & NPT_WR_MASK;

   // Reserved bit is never stored, so it reads zero
   always_comb
   begin
      npt_view          = npt_ff;
      npt_view[TOG_BIT] = tog;
   end

   // Bus answer: ack one cycle after the strobe, dropped next cycle
   always_comb
   begin
      nxt_ack = req;
      nxt_rd  = rd_ff;
      if (req && !wb_we)
      begin
         if (hit_npt)
            nxt_rd = {16'h0000, npt_view};
         else if (hit_rx)
            nxt_rd = {16'h0000, rx_ff};
         else
            nxt_rd = UNMAPPED_DATA;
      end
   end

   // Software fields; only bits 15, 13, 12 and 10..0 are writable
   always_comb
   begin
      nxt_npt = npt_ff;
      if (req && wb_we && hit_npt)
         nxt_npt = (npt_ff & ~lane_mask) |
                   (wb_dat_wr[15:0] & lane_mask);
   end

   // Partner page is read-only to software
   always_comb
   begin
      nxt_rx = rx_ff;
      if (an_restart)
         nxt_rx = RX_RESET;
      else if (rx_page_valid)
         nxt_rx = rx_page;
   end

   // Snapshot at load; a later write waits for the next page
   always_comb
   begin
      nxt_tx = tx_ff;
      if (page_load)
         nxt_tx = npt_view;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         ack_ff <= 1'b0;
         rd_ff  <= UNMAPPED_DATA;
         npt_ff <= NPT_RESET;
         rx_ff  <= RX_RESET;
         tx_ff  <= NPT_RESET;
      end
      else
      begin
         ack_ff <= nxt_ack;
         rd_ff  <= nxt_rd;
         npt_ff <= nxt_npt;
         rx_ff  <= nxt_rx;
         tx_ff  <= nxt_tx;
      end
   end

   assign wb_ack    = ack_ff;
   assign wb_dat_rd = rd_ff;
   assign tx_page   = tx_ff;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   logic wr_npt;
   assign wr_npt = req && wb_we && hit_npt;

   property p_reset_value;
      $rose(reset_n) |-> npt_ff == NPT_RESET && rx_ff == RX_RESET &&
         npt_view[TOG_BIT] == 1'b0;
   endproperty
   a_reset_value: assert property (p_reset_value)
      else $error("register reset value wrong");

   property p_more_pages;
      wr_npt && wb_sel[1] |=> npt_view[NP_BIT] == $past(wb_dat_wr[NP_BIT]);
   endproperty
   a_more_pages: assert property (p_more_pages)
      else $error("more-pages bit not written");

   property p_message;
      wr_npt && wb_sel[1] |=> npt_view[MP_BIT] == $past(wb_dat_wr[MP_BIT]);
   endproperty
   a_message: assert property (p_message)
      else $error("message bit not written");

   property p_comply;
      wr_npt && wb_sel[1] |=>
         npt_view[ACK2_BIT] == $past(wb_dat_wr[ACK2_BIT]);
   endproperty
   a_comply: assert property (p_comply)
      else $error("comply bit not written");

   property p_toggle;
      page_load && !an_restart |=> tx_page[TOG_BIT] != npt_view[TOG_BIT];
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("toggle did not invert after page sent");

   property p_code_sent;
      page_load |=> tx_page[CODE_MSB:0] == $past(npt_ff[CODE_MSB:0]);
   endproperty
   a_code_sent: assert property (p_code_sent)
      else $error("code field not carried to page");

   property p_null_code;
      $rose(reset_n) |-> npt_ff[CODE_MSB:0] == NULL_CODE &&
         npt_ff[MP_BIT];
   endproperty
   a_null_code: assert property (p_null_code)
      else $error("default page is not null message");

   property p_reserved;
      wb_ack && !wb_we && hit_npt |-> wb_dat_rd[RSV_BIT] == 1'b0 &&
         wb_dat_rd[31:16] == 16'h0000;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved bits read nonzero");

   property p_partner;
      rx_page_valid && !an_restart |=> rx_ff == $past(rx_page) ##1
         (!wb_ack || wb_we || !hit_rx || wb_dat_rd[15:0] == rx_ff ||
          $past(rx_page_valid));
   endproperty
   a_partner: assert property (p_partner)
      else $error("partner page not captured");

   property p_hold;
      !page_load [*2] |-> $stable(tx_page);
   endproperty
   a_hold: assert property (p_hold)
      else $error("transmitted page changed outside load");

   property p_ack_pulse;
      wb_ack |=> !wb_ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack held longer than one cycle");

   c_write_tx: cover property (wr_npt ##1 wb_ack);
   c_two_pages: cover property (page_load ##[1:20] page_load);
   c_write_during_page: cover property (page_load ##1 wr_npt);
   c_partner_read: cover property (rx_page_valid ##[1:10]
                                   (wb_ack && !wb_we && hit_rx));
endmodule

// ==== design/annp_toggle.sv ====
// Toggle bit tracker for transmitted next pages
`timescale 1ns/100ps
module annp_toggle
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic reset_n,
   // Arbitration events
   input  wire logic restart,
   input  wire logic sent,
   // Toggle value for the next page
   output logic      tog
);
   logic tog_ff;
   logic nxt_tog;

   // Restart returns to the first-page value
   always_comb
   begin
      nxt_tog = tog_ff;
      if (restart)
         nxt_tog = 1'b0;
      else if (sent)
         nxt_tog = ~tog_ff;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         tog_ff <= 1'b0;
      else
         tog_ff <= nxt_tog;
   end

   assign tog = tog_ff;
endmodule

// ==== include/annp_pkg.sv ====
// Constants for the next page transmit register bank
// How it works
// - Bit 15 more-pages request, read/write, resets zero
// - Bit 13 message/unformatted selector, resets one
// - Bit 12 ability-to-comply acknowledge, resets zero
// - Bit 11 toggle inverts previous sent toggle
// - Bits 10..0 code field, read/write, sent
// - Code resets to one: null message
// - Bit 14 reserved, always reads zero
// - Partner page register index 8, resets zero
// - Transmit register index 7, resets 0x2001
package annp_pkg;
   // Register indices; byte address is four times the index
   localparam logic [3:0]  NPT_IDX       = 4'h7;
   localparam logic [3:0]  RX_IDX        = 4'h8;
   // Field positions
   localparam int          NP_BIT        = 15;
   localparam int          RSV_BIT       = 14;
   localparam int          MP_BIT        = 13;
   localparam int          ACK2_BIT      = 12;
   localparam int          TOG_BIT       = 11;
   localparam int          CODE_MSB      = 10;
   // Reset values
   localparam logic [15:0] NPT_RESET     = 16'h2001;
   localparam logic [15:0] RX_RESET      = 16'h0000;
   localparam logic [10:0] NULL_CODE     = 11'h001;
   // Bits that software may store: all but reserved and toggle
   localparam logic [15:0] NPT_WR_MASK   = 16'hb7ff;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// ==== test/annp_partner.sv ====
// Arbitration-side model driving page events into the bank
`timescale 1ns/100ps
module annp_partner
(
   // Clock
   input  wire logic ref_clk,
   // Arbitration events
   output logic      an_restart,
   output logic      page_load,
   output logic      rx_page_valid,
   output logic [15:0] rx_page
);
   initial
   begin
      {an_restart, page_load, rx_page_valid} = 3'b000;
      rx_page = 16'h0000;
   end
   // 0 restart, 1 page load, 2 partner page; one-cycle pulse
   task automatic pulse(input int which, input logic [15:0] d);
      @(posedge ref_clk);
      an_restart <= (which == 0);
      page_load <= (which == 1);
      rx_page_valid <= (which == 2);
      rx_page <= d;
      @(posedge ref_clk);
      {an_restart, page_load, rx_page_valid} <= 3'b000;
      // Stale data must not look valid
      rx_page <= ~d;
      @(posedge ref_clk);
   endtask
endmodule

// ==== test/autoneg_next_page_tx_regs_test.sv ====
// Self-checking bench for the next page register bank
`timescale 1ns/100ps
module autoneg_next_page_tx_regs_test;
   logic        ref_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        wb_cyc = 1'b0;
   logic        wb_stb = 1'b0;
   logic        wb_we = 1'b0;
   logic [7:0]  wb_adr = 8'h00;
   logic [3:0]  wb_sel = 4'h0;
   logic [31:0] wb_dat_wr = 32'h0;
   logic [31:0] wb_dat_rd, rd;
   logic        wb_ack, an_restart, page_load, rx_page_valid;
   logic [15:0] rx_page, tx_page;
   int          errors, num_checks, cyc_cnt;

   always #2.5 ref_clk = ~ref_clk;

   annp_regs dut (.ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc(wb_cyc),
      .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
      .wb_dat_wr(wb_dat_wr), .wb_dat_rd(wb_dat_rd), .wb_ack(wb_ack),
      .an_restart(an_restart), .page_load(page_load),
      .rx_page_valid(rx_page_valid), .rx_page(rx_page), .tx_page(tx_page));
   annp_partner ptr (.ref_clk(ref_clk), .an_restart(an_restart),
      .page_load(page_load), .rx_page_valid(rx_page_valid),
      .rx_page(rx_page));

   task automatic chk(input string nm, input logic [31:0] exp, got);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Request held until ack is sampled high
   task automatic wb(input logic we, input logic [7:0] a,
      input logic [3:0] s, input logic [15:0] d);
      int n;
      n = 0;
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel} <= {2'b11, we, a, s};
      wb_dat_wr <= {16'h0000, d};
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (wb_ack !== 1'b1 && n < 20);
      rd = wb_dat_rd;
      if (wb_ack !== 1'b1)
      begin
         errors++;
         $display("wrong value wb_ack expected 1 seen %b", wb_ack);
      end
      {wb_cyc, wb_stb} <= 2'b00;
      @(posedge ref_clk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 4'h3, 16'h0000);
      chk($sformatf("reg %h", a), exp, rd);
   endtask
   task automatic t_reset;
      rdc(8'h1c, 32'h0000_2001);
      rdc(8'h20, 32'h0000_0000);
      chk("tx_page", 32'h2001, {16'h0, tx_page});
   endtask
   task automatic t_fields;
      wb(1'b1, 8'h1c, 4'h3, 16'hffff);
      rdc(8'h1c, 32'h0000_b7ff);
      wb(1'b1, 8'h1c, 4'h1, 16'h0000);
      rdc(8'h1c, 32'h0000_b700);
   endtask
   task automatic t_ignored;
      wb(1'b1, 8'h20, 4'h3, 16'hffff);
      rdc(8'h20, 32'h0000_0000);
      wb(1'b1, 8'h3c, 4'h3, 16'hffff);
      rdc(8'h3c, 32'h0000_0000);
   endtask
   task automatic t_snapshot;
      ptr.pulse(1, 16'h0000);
      chk("tx_page", 32'hb700, {16'h0, tx_page});
      rdc(8'h1c, 32'h0000_bf00);
      wb(1'b1, 8'h1c, 4'h3, 16'h0000);
      chk("tx_page", 32'hb700, {16'h0, tx_page});
      rdc(8'h1c, 32'h0000_0800);
      ptr.pulse(1, 16'h0000);
      chk("tx_page", 32'h0800, {16'h0, tx_page});
      rdc(8'h1c, 32'h0000_0000);
   endtask
   task automatic t_partner;
      ptr.pulse(2, 16'ha5c3);
      rdc(8'h20, 32'h0000_a5c3);
      ptr.pulse(1, 16'h0000);
      ptr.pulse(0, 16'h0000);
      rdc(8'h1c, 32'h0000_0000);
      rdc(8'h20, 32'h0000_0000);
   endtask
   task automatic end_sim;
      if (errors == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      repeat (6) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      t_reset;
      t_fields;
      t_ignored;
      t_snapshot;
      t_partner;
      end_sim;
   end
   // Whole run needs well under 200 cycles
   always @(posedge ref_clk)
   begin
      cyc_cnt++;
      if (cyc_cnt == 2000)
      begin
         errors++;
         end_sim;
      end
   end
endmodule
